// ---- acrb_bank.sv ----
// Purpose: Configuration register bank of a two-channel delta-sigma converter.
// Assumes: A serial front end delivers decoded word writes and reads on CLK.
// Notes: Decoded settings leave on registered outputs for the converter core.
// Functional notes
// R1: Ready pin holds low or pulses.
// R2: Source field picks lagging, OR, or leading.
// R3: Idle pin drives high or floats.
// R4: Channel converters run only when enabled.
// R5: Fixed ratio 64 overrides ratio field.
// R6: Ratio codes map 128 up to 16256.
// R7: Power code selects very-low, low, high.
// R8: Channel 1 gain is power of two.
// R9: Channel 0 gain same power-of-two coding.
// R10: Rate/power register resets to 030E.
// R11: Spare word resets zero, no effect.
// R12: Host writes zero to reserved bits.
`timescale 1ns/1ps
`include "acrb_params.svh"
module acrb_bank #(
  parameter int PULSE_CYC = `ACRB_PULSE_CYC
) (
  input wire logic CLK,                 // System clock, 100 MHz.
  input wire logic SYS_RST,             // Synchronous reset, active high.
  input wire logic REG_WR,              // Write strobe, one cycle.
  input wire logic REG_RD,              // Read strobe, one cycle.
  input wire logic [3:0] REG_ADDR,      // Register address.
  input wire logic [15:0] REG_WDATA,    // Write data.
  output logic [15:0] REG_RDATA,        // Read data, valid cycle after REG_RD.
  output logic REG_RVALID,              // Read data valid pulse.
  input wire logic [1:0] CHAN_READY,    // Per-channel conversion done pulses.
  input wire logic DATA_READ,           // Host read the conversion data.
  output logic SAMPLE_READY_PIN_O,      // Ready pin level.
  output logic SAMPLE_READY_PIN_OE_N,   // Ready pin drive enable, low drives.
  output logic CHAN0_CONVERT_ON,        // Channel 0 converter run.
  output logic CHAN1_CONVERT_ON,        // Channel 1 converter run.
  output logic [13:0] RATIO_VALUE,      // Effective oversampling ratio.
  output logic [1:0] POWER_LEVEL,       // Decoded power level.
  output logic [7:0] CHAN0_GAIN,        // Channel 0 amplifier gain.
  output logic [7:0] CHAN1_GAIN         // Channel 1 amplifier gain.
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Ratio code to oversampling ratio; the top code is not a power of two.
  // R6: ratio code table
  function automatic logic [13:0] ratio_of(input logic [2:0] code);
    logic [13:0] r;
    r = 14'h0000;
    case (code)
      3'h7: r = 14'h3F80;
      default: r = 14'(14'h0080 << code);
    endcase
    return r;
  endfunction

  // Gain code to power-of-two gain.
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    return 8'(8'h01 << code);
  endfunction

  // Write strobe aimed at one register address.
  function automatic logic hit(input logic wr, input logic [3:0] a,
                               input logic [3:0] target);
    return wr && (a == target);
  endfunction

  // Effective ratio of a rate word; the fixed ratio bit beats the code.
  // R5: fixed ratio override
  function automatic logic [13:0] ratio_eff(input logic [15:0] w);
    logic [13:0] r;
    r = ratio_of(w[`ACRB_OSR_LSB +: 3]);
    if (w[`ACRB_TURBO_BIT]) begin
      r = 14'h0040;
    end
    return r;
  endfunction

  // Power level of a rate word; both upper codes mean high resolution.
  // R7: power code decode
  function automatic logic [1:0] power_of(input logic [15:0] w);
    logic [1:0] p;
    p = acrb_pkg::PWR_HIRES;
    case (w[`ACRB_PWR_LSB +: 2])
      2'b00: p = acrb_pkg::PWR_VLOW;
      2'b01: p = acrb_pkg::PWR_LOW;
      default: p = acrb_pkg::PWR_HIRES;
    endcase
    return p;
  endfunction

  // Read mux for one address.
  function automatic logic [15:0] pick(input logic [3:0] a, input logic [15:0] m,
                                       input logic [15:0] s, input logic [15:0] g,
                                       input logic [15:0] p);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      `ACRB_ADDR_MODE: v = m;
      `ACRB_ADDR_SRPC: v = s;
      `ACRB_ADDR_GAIN: v = g;
      `ACRB_ADDR_SPARE: v = p;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [15:0] mode_q, mode_d;
  logic [15:0] srpc_q, srpc_d;
  logic [15:0] gain_q, gain_d;
  logic [15:0] spare_q, spare_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // Mode word; only the ready pin bits act here, the rest is kept for readback.
  always_comb begin
    mode_d = mode_q;
    if (hit(REG_WR, REG_ADDR, `ACRB_ADDR_MODE)) begin
      mode_d = REG_WDATA & `ACRB_MASK_MODE;
    end
  end

  // Mode word flop.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mode_q <= `ACRB_RST_MODE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Rate and power word; the top six bits are read only and stay zero.
  always_comb begin
    srpc_d = srpc_q;
    if (hit(REG_WR, REG_ADDR, `ACRB_ADDR_SRPC)) begin
      srpc_d = REG_WDATA & `ACRB_MASK_SRPC;
    end
  end

  // Rate and power word flop.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      // R10: rate/power default value
      srpc_q <= `ACRB_RST_SRPC;
    end else begin
      srpc_q <= srpc_d;
    end
  end

  // Gain word; reserved bits are stored as written, the host keeps them zero.
  always_comb begin
    gain_d = gain_q;
    if (hit(REG_WR, REG_ADDR, `ACRB_ADDR_GAIN)) begin
      gain_d = REG_WDATA & `ACRB_MASK_GAIN;
    end
  end

  // Gain word flop.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      gain_q <= `ACRB_RST_GAIN;
    end else begin
      gain_q <= gain_d;
    end
  end

  // Spare word; nothing downstream reads it, so it cannot steer the converters.
  always_comb begin
    spare_d = spare_q;
    // R11: spare word storage only
    if (hit(REG_WR, REG_ADDR, `ACRB_ADDR_SPARE)) begin
      spare_d = REG_WDATA & `ACRB_MASK_SPARE;
    end
  end

  // Spare word flop.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      // R11: spare word cleared
      spare_q <= `ACRB_RST_SPARE;
    end else begin
      spare_q <= spare_d;
    end
  end

  // Read port; a read and a write in one cycle return the old word.
  always_comb begin
    rvalid_d = REG_RD;
    rdata_d = rdata_q;
    if (REG_RD) begin
      rdata_d = pick(REG_ADDR, mode_q, srpc_q, gain_q, spare_q);
    end
  end

  // Read port flops; the data word holds until the next read.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings for the converter core.

  logic ch0_q, ch0_d, ch1_q, ch1_d;
  logic [13:0] ratio_q, ratio_d;
  logic [1:0] pwr_q, pwr_d;
  logic [7:0] g0_q, g0_d, g1_q, g1_d;

  // Default words, so the settings flops reset to the decode of the defaults.
  localparam logic [15:0] RST_SRPC = `ACRB_RST_SRPC;
  localparam logic [15:0] RST_GAIN = `ACRB_RST_GAIN;

  // Channel run enables follow their bits one cycle later.
  always_comb begin
    // R4: channel run enables
    ch0_d = srpc_q[`ACRB_CHAN0_CONVERT_ON_BIT];
    ch1_d = srpc_q[`ACRB_CHAN1_CONVERT_ON_BIT];
  end

  // Channel enable flops.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ch0_q <= RST_SRPC[`ACRB_CHAN0_CONVERT_ON_BIT];
      ch1_q <= RST_SRPC[`ACRB_CHAN1_CONVERT_ON_BIT];
    end else begin
      ch0_q <= ch0_d;
      ch1_q <= ch1_d;
    end
  end

  // Effective oversampling ratio.
  always_comb begin
    // R5: fixed ratio override
    ratio_d = ratio_eff(srpc_q);
  end

  // Ratio flop.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ratio_q <= ratio_eff(RST_SRPC);
    end else begin
      ratio_q <= ratio_d;
    end
  end

  // Power level.
  always_comb begin
    // R7: power code decode
    pwr_d = power_of(srpc_q);
  end

  // Power level flop.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pwr_q <= power_of(RST_SRPC);
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // Amplifier gains, one power of two per channel.
  always_comb begin
    // R8: channel 1 gain
    g1_d = gain_of(gain_q[`ACRB_G1_LSB +: 3]);
    // R9: channel 0 gain
    g0_d = gain_of(gain_q[`ACRB_G0_LSB +: 3]);
  end

  // Gain flops.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      g0_q <= gain_of(RST_GAIN[`ACRB_G0_LSB +: 3]);
      g1_q <= gain_of(RST_GAIN[`ACRB_G1_LSB +: 3]);
    end else begin
      g0_q <= g0_d;
      g1_q <= g1_d;
    end
  end

  assign CHAN0_CONVERT_ON = ch0_q;
  assign CHAN1_CONVERT_ON = ch1_q;
  assign RATIO_VALUE = ratio_q;
  assign POWER_LEVEL = pwr_q;
  assign CHAN0_GAIN = g0_q;
  assign CHAN1_GAIN = g1_q;

  ////////////////////////////////////////////////////////////////////////////
  // Ready pin driver; disabled channels never raise events.

  // R1: ready pin format
  acrb_ready_pin #(
    .PULSE_CYC(PULSE_CYC)
  ) u_ready (
    .clk(CLK),
    .rst(SYS_RST),
    .chan_ready(CHAN_READY),
    .chan_on({ch1_q, ch0_q}),
    .data_read(DATA_READ),
    .source_choice(mode_q[`ACRB_SEL_LSB +: 2]),
    .pulse_format(mode_q[`ACRB_FMT_BIT]),
    .idle_float(mode_q[`ACRB_FLOAT_BIT]),
    .pin_out(SAMPLE_READY_PIN_O),
    .pin_oe_n(SAMPLE_READY_PIN_OE_N)
  );
endmodule

// ---- acrb_params.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the config bank.
// Assumes: Word addresses on the register port, 16-bit data.
// Notes: Included by the bank and ready-pin design modules.
`ifndef ACRB_PARAMS_SVH
`define ACRB_PARAMS_SVH

// Register addresses.
`define ACRB_ADDR_MODE 4'h2
`define ACRB_ADDR_SRPC 4'h3
`define ACRB_ADDR_GAIN 4'h4
`define ACRB_ADDR_SPARE 4'h5

// Reset values.
`define ACRB_RST_MODE 16'h0510
`define ACRB_RST_SRPC 16'h030E
`define ACRB_RST_GAIN 16'h0000
`define ACRB_RST_SPARE 16'h0000

// Writable bit masks; reserved read-only bits read as zero.
`define ACRB_MASK_MODE 16'hFFFF
`define ACRB_MASK_SRPC 16'h03FF
`define ACRB_MASK_GAIN 16'hFFFF
`define ACRB_MASK_SPARE 16'hFFFF

// Mode register fields.
`define ACRB_FMT_BIT 0
`define ACRB_FLOAT_BIT 1
`define ACRB_SEL_LSB 2

// Sample rate and power fields.
`define ACRB_PWR_LSB 0
`define ACRB_OSR_LSB 2
`define ACRB_TURBO_BIT 5
`define ACRB_CHAN0_CONVERT_ON_BIT 8
`define ACRB_CHAN1_CONVERT_ON_BIT 9

// Gain fields.
`define ACRB_G0_LSB 0
`define ACRB_G1_LSB 4

// Fixed ready-pulse length.
`define ACRB_PULSE_NS 40
`define ACRB_CLK_NS 10
`define ACRB_PULSE_CYC ((`ACRB_PULSE_NS + `ACRB_CLK_NS - 1) / `ACRB_CLK_NS)

`endif

// ---- acrb_pkg.sv ----
// Purpose: Types shared by the config bank modules.
// Assumes: Constants come from acrb_params.svh.
// Notes: Types only.
package acrb_pkg;
  typedef enum logic [1:0] {PWR_VLOW, PWR_LOW, PWR_HIRES} acrb_power_t;
  typedef enum logic [1:0] {SRC_LAG, SRC_OR, SRC_LEAD} acrb_src_t;
  typedef enum {RDY_IDLE, RDY_PULSE, RDY_HOLD} acrb_rdy_state_t;
endpackage

// ---- acrb_ready_pin.sv ----
// Purpose: Drive the sample-ready pin from per-channel data-ready events.
// Assumes: Events and settings come from logic on the same clock.
// Notes: Output enable is low while the pin is driven.
`timescale 1ns/1ps
`include "acrb_params.svh"
module acrb_ready_pin #(
  parameter int PULSE_CYC = `ACRB_PULSE_CYC
) (
  input wire logic clk,                 // System clock.
  input wire logic rst,                 // Synchronous reset, active high.
  input wire logic [1:0] chan_ready,    // One-cycle data-ready per channel.
  input wire logic [1:0] chan_on,       // Channel enables.
  input wire logic data_read,           // Host has read the data.
  input wire logic [1:0] source_choice, // Ready source select.
  input wire logic pulse_format,        // 1 gives a fixed low pulse.
  input wire logic idle_float,          // 1 floats the pin when idle.
  output logic pin_out,                 // Pin level.
  output logic pin_oe_n                 // Pin drive enable, low drives.
);
  localparam int CW = $clog2(PULSE_CYC + 1);

  logic [1:0] seen_q, seen_d;
  logic [CW-1:0] cnt_q, cnt_d;
  acrb_pkg::acrb_rdy_state_t st_q, st_d;
  logic pin_q, pin_d, oe_n_q, oe_n_d;
  logic [1:0] ev;
  logic fire;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and pin state machine.
  always_comb begin
    ev = chan_ready & chan_on;
    seen_d = seen_q;
    fire = 1'b0;
    // R2: source select decode
    case (source_choice)
      2'b00: begin
        // Lagging: fire once every enabled channel has reported.
        seen_d = seen_q | ev;
        if ((chan_on != 2'b00) && ((seen_d & chan_on) == chan_on)) begin
          fire = 1'b1;
          seen_d = 2'b00;
        end
      end
      2'b01: begin
        fire = |ev;
      end
      default: begin
        // Leading: first enabled channel of a set fires, the rest are absorbed.
        seen_d = seen_q | ev;
        if ((seen_q == 2'b00) && (ev != 2'b00)) begin
          fire = 1'b1;
        end
        if ((seen_d & chan_on) == chan_on) begin
          seen_d = 2'b00;
        end
      end
    endcase
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      acrb_pkg::RDY_IDLE: begin
        if (fire) begin
          // R1: choose low level or pulse
          st_d = pulse_format ? acrb_pkg::RDY_PULSE : acrb_pkg::RDY_HOLD;
          cnt_d = CW'(PULSE_CYC - 1);
        end
      end
      acrb_pkg::RDY_PULSE: begin
        if (cnt_q == '0) begin
          st_d = acrb_pkg::RDY_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      acrb_pkg::RDY_HOLD: begin
        if (data_read) begin
          st_d = acrb_pkg::RDY_IDLE;
        end
      end
      default: begin
        st_d = acrb_pkg::RDY_IDLE;
      end
    endcase
    // R3: idle drive or float
    if (st_d == acrb_pkg::RDY_IDLE) begin
      pin_d = 1'b1;
      oe_n_d = idle_float;
    end else begin
      pin_d = 1'b0;
      oe_n_d = 1'b0;
    end
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_q <= 2'b00;
      cnt_q <= '0;
      st_q <= acrb_pkg::RDY_IDLE;
      pin_q <= 1'b1;
      oe_n_q <= 1'b0;
    end else begin
      seen_q <= seen_d;
      cnt_q <= cnt_d;
      st_q <= st_d;
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_out = pin_q;
  assign pin_oe_n = oe_n_q;
endmodule

// ---- acrb_host.sv ----
// Purpose: Host model that speaks the register port of the config bank.
// Assumes: Strobes change only after a falling clock edge.
// Notes: Read data is taken once the valid pulse is up.
`timescale 1ns/1ps
module acrb_host (
  input wire logic clk, // System clock.
  output logic wr, // Write strobe.
  output logic rd, // Read strobe.
  output logic [3:0] addr, // Word address.
  output logic [15:0] wdata, // Write data.
  input wire logic [15:0] rdata, // Read data.
  input wire logic rvalid // Read data valid.
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle port at time zero.
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
  end
  function automatic logic [15:0] keep(input logic [3:0] a);
    case (a)
      4'h2: keep = 16'h3F1F;
      4'h3: keep = 16'h033F;
      4'h4: keep = 16'h0077;
      default: keep = 16'h0000;
    endcase
  endfunction
  // One write; the strobe spans exactly one rising edge.
  task automatic wr_word(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d & keep(a);
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // One read; the answer is taken in the valid cycle.
  task automatic rd_word(input logic [3:0] a, output logic [15:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rvalid ? rdata : 16'hXXXX;
  endtask
endmodule

// ---- acrb_bank_chk.sv ----
// Purpose: Port-level assertions for the config bank.
// Assumes: Bound to acrb_bank and sees only its ports.
// Notes: Decoded outputs follow a write by two cycles.
`timescale 1ns/1ps
module acrb_bank_chk #(
  parameter int PULSE_CYC = 4
) (
  input wire logic CLK, // Clock.
  input wire logic SYS_RST, // Reset.
  input wire logic REG_WR, // Write strobe.
  input wire logic REG_RD, // Read strobe.
  input wire logic [3:0] REG_ADDR, // Address.
  input wire logic [15:0] REG_WDATA, // Write data.
  input wire logic REG_RVALID, // Read valid.
  input wire logic SAMPLE_READY_PIN_O, // Pin level.
  input wire logic SAMPLE_READY_PIN_OE_N, // Pin enable.
  input wire logic CHAN0_CONVERT_ON, // Channel 0 run.
  input wire logic CHAN1_CONVERT_ON, // Channel 1 run.
  input wire logic [13:0] RATIO_VALUE, // Ratio.
  input wire logic [1:0] POWER_LEVEL, // Power level.
  input wire logic [7:0] CHAN0_GAIN, // Gain 0.
  input wire logic [7:0] CHAN1_GAIN // Gain 1.
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////////
  // Accepted writes to the rate and gain words.
  wire logic wr_rate = REG_WR && REG_ADDR == 4'h3;
  wire logic wr_gain = REG_WR && REG_ADDR == 4'h4;
  ////////////////////////////////////////////////////////////////////////////////
  a_read_valid: assert property (REG_RD |=> REG_RVALID)
    else $error("read valid missing");
  a_valid_cause: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("read valid without read");
  a_turbo_ratio: assert property (wr_rate && REG_WDATA[5] |-> ##2 RATIO_VALUE == 14'h0040)
    else $error("fixed ratio not applied");
  a_ratio_code: assert property (wr_rate && !REG_WDATA[5] && REG_WDATA[4:2] != 3'h7
    |-> ##2 RATIO_VALUE == (14'h0080 << $past(REG_WDATA[4:2], 2))) else $error("bad ratio");
  a_chan_enable: assert property (wr_rate |-> ##2
    {CHAN1_CONVERT_ON, CHAN0_CONVERT_ON} == $past(REG_WDATA[9:8], 2)) else $error("bad enable");
  a_power_map: assert property (wr_rate |-> ##2 POWER_LEVEL ==
    ($past(REG_WDATA[1], 2) ? 2'h2 : {1'b0, $past(REG_WDATA[0], 2)})) else $error("bad power");
  a_gain_map: assert property (wr_gain |-> ##2
    CHAN1_GAIN == (8'h01 << $past(REG_WDATA[6:4], 2)) &&
    CHAN0_GAIN == (8'h01 << $past(REG_WDATA[2:0], 2))) else $error("bad gain");
  a_reset_defaults: assert property ($fell(SYS_RST) |-> RATIO_VALUE == 14'h0400 &&
    POWER_LEVEL == 2'h2 && CHAN0_CONVERT_ON && CHAN1_CONVERT_ON) else $error("bad defaults");
  a_low_driven: assert property (!SAMPLE_READY_PIN_O |-> !SAMPLE_READY_PIN_OE_N)
    else $error("ready low but floating");
  a_idle_reset: assert property ($fell(SYS_RST) |-> SAMPLE_READY_PIN_O &&
    !SAMPLE_READY_PIN_OE_N) else $error("pin not idle high");
  // Main scenarios reached.
  c_rate_write: cover property (wr_rate);
  c_pin_fell: cover property ($fell(SAMPLE_READY_PIN_O));
  c_read: cover property (REG_RVALID);
endmodule
bind acrb_bank acrb_bank_chk #(.PULSE_CYC(PULSE_CYC)) chk (.CLK, .SYS_RST, .REG_WR, .REG_RD,
  .REG_ADDR, .REG_WDATA, .REG_RVALID, .SAMPLE_READY_PIN_O, .SAMPLE_READY_PIN_OE_N,
  .CHAN0_CONVERT_ON, .CHAN1_CONVERT_ON, .RATIO_VALUE, .POWER_LEVEL, .CHAN0_GAIN, .CHAN1_GAIN);

// ---- acrb_bank_tb.sv ----
// Purpose: Self-checking bench for the config bank.
// Assumes: Pulse length parameter set to 4 cycles.
// Notes: Inputs change at the falling edge.
`timescale 1ns/1ps
module acrb_bank_tb;
  logic clk;
  logic sys_rst;
  logic wr;
  logic rd;
  logic data_read;
  logic pin_o;
  logic pin_oe_n;
  logic ch0_on;
  logic ch1_on;
  logic rvalid;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [1:0] chan_ready;
  logic [1:0] power;
  logic [13:0] ratio;
  logic [7:0] gain0;
  logic [7:0] amplifier_gain_select;
  int mismatches;
  int check_count;
  ////////////////////////////////////////////////////////////////////////////////
  acrb_bank #(.PULSE_CYC(4)) DUT (
    .CLK(clk), .SYS_RST(sys_rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .CHAN_READY(chan_ready),
    .DATA_READ(data_read), .SAMPLE_READY_PIN_O(pin_o), .SAMPLE_READY_PIN_OE_N(pin_oe_n),
    .CHAN0_CONVERT_ON(ch0_on), .CHAN1_CONVERT_ON(ch1_on), .RATIO_VALUE(ratio),
    .POWER_LEVEL(power), .CHAN0_GAIN(gain0), .CHAN1_GAIN(amplifier_gain_select));
  acrb_host host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata),
    .rvalid(rvalid));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Print the verdict and stop.
  task automatic tally_and_finish();
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Fire events and count the cycles the pin then stays low.
  task automatic fire(input logic [1:0] b, output int n);
    @(negedge clk);
    chan_ready = b;
    @(negedge clk);
    chan_ready = 2'h0;
    n = 0;
    while (pin_o === 1'b0 && n < 20) begin
      n++;
      @(negedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset contents and decoded defaults.
  task automatic t_reset();
    logic [15:0] v;
    host.rd_word(4'h3, v);
    check("rate word", v, 16'h030E);
    host.rd_word(4'h5, v);
    check("spare word", v, 16'h0000);
    host.rd_word(4'h2, v);
    check("mode word", v, 16'h0510);
    host.rd_word(4'h4, v);
    check("gain word", v, 16'h0000);
    check("gains", {amplifier_gain_select, gain0}, 16'h0101);
    check("idle pin", {14'h0, pin_o, pin_oe_n}, 16'h0002);
  endtask
  // Every ratio, power and enable code, then the fixed ratio.
  task automatic t_rates();
    logic [15:0] v;
    for (int c = 0; c < 8; c++) begin
      host.wr_word(4'h3, {6'h00, c[1:0], 3'h0, c[2:0], c[1:0]});
      repeat (2) @(negedge clk);
      check("ratio", {2'h0, ratio}, c == 7 ? 16'h3F80 : 16'h0080 << c);
      check("power", {14'h0, power}, c[1] ? 16'h0002 : {15'h0, c[0]});
      check("enables", {14'h0, ch1_on, ch0_on}, {14'h0, c[1:0]});
    end
    host.wr_word(4'h3, 16'h033C);
    repeat (2) @(negedge clk);
    check("fixed ratio", {2'h0, ratio}, 16'h0040);
    host.rd_word(4'h3, v);
    check("rate readback", v, 16'h033C);
    host.wr_word(4'h3, 16'h030E);
  endtask
  // Every gain code on both channels.
  task automatic t_gains();
    for (int c = 0; c < 8; c++) begin
      host.wr_word(4'h4, {9'h000, c[2:0], 1'b0, 3'h7 - c[2:0]});
      repeat (2) @(negedge clk);
      check("amplifier_gain_select", {8'h00, amplifier_gain_select}, {8'h00, 8'h01 << c[2:0]});
      check("gain0", {8'h00, gain0}, {8'h00, 8'h80 >> c[2:0]});
    end
  endtask
  // Ready pin sources, formats and idle states.
  task automatic t_ready();
    int n;
    host.wr_word(4'h2, 16'h0515);
    fire(2'b01, n);
    check("or pulse", n[15:0], 16'h0004);
    check("idle high", {14'h0, pin_o, pin_oe_n}, 16'h0002);
    host.wr_word(4'h2, 16'h0511);
    fire(2'b01, n);
    check("lag first", n[15:0], 16'h0000);
    fire(2'b10, n);
    check("lag last", n[15:0], 16'h0004);
    host.wr_word(4'h2, 16'h0519);
    fire(2'b01, n);
    check("lead first", n[15:0], 16'h0004);
    fire(2'b10, n);
    check("lead rest", n[15:0], 16'h0000);
    host.wr_word(4'h2, 16'h051F);
    fire(2'b10, n);
    check("lead again", n[15:0], 16'h0004);
    check("idle float", {15'h0, pin_oe_n}, 16'h0001);
    host.wr_word(4'h2, 16'h0514);
    fire(2'b11, n);
    check("held low", n[15:0], 16'd20);
    data_read = 1'b1;
    @(negedge clk);
    data_read = 1'b0;
    @(negedge clk);
    check("released", {15'h0, pin_o}, 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    chan_ready = 2'h0;
    data_read = 1'b0;
    mismatches = 0;
    check_count = 0;
    // Two full rising edges under reset, then release off the edge.
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_rates();
    t_gains();
    t_ready();
    tally_and_finish();
  end
  // Watchdog well past the roughly 145 cycles the tests need.
  initial begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
endmodule
